// *** hw/qlma_mac_unit.sv ***
// Single-lane Q15 fractional multiply-accumulate unit with four accumulators
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module qlma_mac_unit (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        issue_valid,
    input  wire logic [31:0] instr,
    input  wire logic [63:0] operand_one_register,
    input  wire logic [63:0] operand_two_register,
    input  wire logic        ext_enable,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [63:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [63:0] reg_rdata,
    output logic             op_done,
    output logic             op_saturated,
    output logic             exc_reserved,
    output logic             exc_ext_disabled,
    output logic      [3:0]  sat_flags
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] pick_lane(
        input logic [63:0]             r,
        input qlma_pkg::qlma_lane_e    l
    );
        case (l)
            qlma_pkg::LANE_TOP:    pick_lane = r[qlma_pkg::LANE3_LSB +: 16];
            qlma_pkg::LANE_UPMID:  pick_lane = r[qlma_pkg::LANE2_LSB +: 16];
            qlma_pkg::LANE_LOWMID: pick_lane = r[qlma_pkg::LANE1_LSB +: 16];
            default:               pick_lane = r[qlma_pkg::LANE0_LSB +: 16];
        endcase
    endfunction

    // Returns {saturated, q31 value}
    function automatic logic [32:0] q15_mul(
        input logic [15:0] a,
        input logic [15:0] b
    );
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (a == qlma_pkg::Q15_NEG_ONE && b == qlma_pkg::Q15_NEG_ONE) begin
            q15_mul = {1'b1, qlma_pkg::Q31_MAX};
        end else begin
            q15_mul = {1'b0, p[30:0], 1'b0};
        end
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [5:0]  f_major;
    logic [2:0]  f_zero;
    logic [1:0]  sel;
    logic [4:0]  f_sub;
    logic [5:0]  f_func;
    logic        quad_hit;
    logic        pair_hit;
    logic        known;
    logic        legal;
    logic        accept;
    logic        sat_mode;
    qlma_pkg::qlma_lane_e lane;

    assign f_major = instr[qlma_pkg::MAJOR_MSB:qlma_pkg::MAJOR_LSB];
    assign f_zero  = instr[qlma_pkg::ZERO_MSB:qlma_pkg::ZERO_LSB];
    assign sel     = instr[qlma_pkg::SEL_MSB:qlma_pkg::SEL_LSB];
    assign f_sub   = instr[qlma_pkg::SUB_MSB:qlma_pkg::SUB_LSB];
    assign f_func  = instr[qlma_pkg::FUNC_MSB:qlma_pkg::FUNC_LSB];

    always_comb begin
        quad_hit = 1'b0;
        sat_mode = 1'b1;
        lane     = qlma_pkg::LANE_LOW;
        pair_hit = f_major == qlma_pkg::MAJOR_OP_GROUP3
                && f_func == qlma_pkg::FUNC_PAIR_MAC
                && f_sub == qlma_pkg::SUB_PAIR_LOW_SAT;
        if (f_major == qlma_pkg::MAJOR_OP_GROUP3
            && f_func == qlma_pkg::FUNC_QUAD_MAC) begin
            quad_hit = 1'b1;
            case (f_sub)
                qlma_pkg::SUB_LANE3: begin
                    lane     = qlma_pkg::LANE_TOP;
                    sat_mode = 1'b0;
                end
                qlma_pkg::SUB_LANE3_SATACC: begin
                    lane = qlma_pkg::LANE_TOP;
                end
                qlma_pkg::SUB_LANE2: begin
                    lane     = qlma_pkg::LANE_UPMID;
                    sat_mode = 1'b0;
                end
                qlma_pkg::SUB_LANE2_SATACC: begin
                    lane = qlma_pkg::LANE_UPMID;
                end
                qlma_pkg::SUB_LANE1: begin
                    lane     = qlma_pkg::LANE_LOWMID;
                    sat_mode = 1'b0;
                end
                qlma_pkg::SUB_LANE1_SATACC: begin
                    lane = qlma_pkg::LANE_LOWMID;
                end
                default: begin
                    // Other members of the function group belong elsewhere
                    quad_hit = 1'b0;
                end
            endcase
        end
    end

    assign known  = quad_hit || pair_hit;
    assign legal  = known && f_zero == qlma_pkg::ZERO_FIELD;
    assign accept = clk_en && issue_valid && legal && ext_enable;

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    logic [127:0] acc_mem [qlma_pkg::ACC_COUNT];
    logic [127:0] cur_acc;
    logic [15:0]  lane_a;
    logic [15:0]  lane_b;
    logic [32:0]  mul_out;
    logic [31:0]  prod;
    logic         mul_sat;
    logic [127:0] sum;
    logic         acc_ovf;
    logic [31:0]  clamped;
    logic [127:0] next_acc;
    logic         any_sat;

    assign cur_acc = acc_mem[sel];
    assign lane_a  = pick_lane(operand_one_register, lane);
    assign lane_b  = pick_lane(operand_two_register, lane);
    assign mul_out = q15_mul(lane_a, lane_b);
    assign mul_sat = mul_out[32];
    assign prod    = mul_out[31:0];
    // Full-width add so the plain form never wraps early
    assign sum     = cur_acc + {{96{prod[31]}}, prod};
    assign acc_ovf = sum[32] != sum[31];

    always_comb begin
        clamped = sum[31:0];
        if (acc_ovf) begin
            clamped = sum[32] ? qlma_pkg::Q31_MAX : qlma_pkg::Q31_MIN;
        end
    end

    // Pair form stores each sign-extended half; both collapse to the
    // same 128-bit sign extension of the clamped word.
    assign next_acc = sat_mode ? {{96{clamped[31]}}, clamped}
                               : sum;
    assign any_sat  = mul_sat || (sat_mode && acc_ovf);

    // ------------------------------------------------------------------
    // Accumulators and control word
    // ------------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] next_ctrl;
    logic [3:0]  set_mask;
    logic        wr_ctrl;
    logic        wr_half;
    logic [1:0]  wr_acc;

    assign wr_ctrl = reg_wr && reg_addr == qlma_pkg::REG_CTRL;
    assign wr_half = reg_wr && reg_addr[3] == qlma_pkg::REG_ACC_BASE[3];
    assign wr_acc  = reg_addr[2:1];

    // Updates land at the issuing edge, so a back-to-back op sees them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < qlma_pkg::ACC_COUNT; i++) begin
                acc_mem[i] <= {qlma_pkg::HALF_RESET, qlma_pkg::HALF_RESET};
            end
        end else if (clk_en) begin
            if (wr_half && !(accept && wr_acc == sel)) begin
                if (reg_addr[0]) begin
                    acc_mem[wr_acc][63:0] <= reg_wdata;
                end else begin
                    acc_mem[wr_acc][127:64] <= reg_wdata;
                end
            end
            if (accept) begin
                acc_mem[sel] <= next_acc;
            end
        end
    end

    always_comb begin
        set_mask = 4'h0;
        if (accept && any_sat) begin
            set_mask[sel] = 1'b1;
        end
        next_ctrl = wr_ctrl ? reg_wdata[31:0] : ctrl_word;
        // A saturation in the clearing cycle is kept
        next_ctrl[qlma_pkg::FLAG_LSB +: 4] =
            next_ctrl[qlma_pkg::FLAG_LSB +: 4] | set_mask;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_word <= qlma_pkg::CTRL_RESET;
        end else if (clk_en) begin
            ctrl_word <= next_ctrl;
        end
    end

    assign sat_flags = ctrl_word[qlma_pkg::FLAG_LSB +: 4];

    // ------------------------------------------------------------------
    // Status pulses
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_done          <= 1'b0;
            op_saturated     <= 1'b0;
            exc_reserved     <= 1'b0;
            exc_ext_disabled <= 1'b0;
        end else if (clk_en) begin
            op_done      <= accept;
            op_saturated <= accept && any_sat;
            // Saturation never traps; only decode faults and a disabled extension do
            exc_reserved <= issue_valid && known && !legal;
            exc_ext_disabled <= issue_valid && legal && !ext_enable;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= qlma_pkg::HALF_RESET;
        end else if (clk_en) begin
            reg_rdata <= qlma_pkg::HALF_RESET;
            if (reg_rd) begin
                if (reg_addr == qlma_pkg::REG_CTRL) begin
                    reg_rdata <= {32'h00000000, ctrl_word};
                end else if (reg_addr[3] == qlma_pkg::REG_ACC_BASE[3]) begin
                    reg_rdata <= reg_addr[0] ? acc_mem[wr_acc][63:0]
                                             : acc_mem[wr_acc][127:64];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_lane_top: assert property (
        accept && lane == qlma_pkg::LANE_TOP
        |-> lane_a == operand_one_register[63:48]
            && lane_b == operand_two_register[63:48])
        else $error("top lane operands wrong");

    chk_lane_upmid: assert property (
        accept && f_sub == qlma_pkg::SUB_LANE2
        |-> lane_a == operand_one_register[47:32])
        else $error("upper-middle lane operand wrong");

    chk_lane_lowmid: assert property (
        accept && f_func == qlma_pkg::FUNC_QUAD_MAC
        && f_sub == qlma_pkg::SUB_LANE1_SATACC
        |-> lane_b == operand_two_register[31:16])
        else $error("lower-middle lane operand wrong");

    chk_prod_shift: assert property (
        accept && !mul_sat
        |-> $signed(prod) == 32'($signed(lane_a) * $signed(lane_b) * 2))
        else $error("product not doubled");

    chk_prod_sat: assert property (
        accept && lane_a == 16'h8000 && lane_b == 16'h8000
        |=> op_saturated && sat_flags[$past(sel)])
        else $error("minus one squared not saturated");

    chk_plain_add: assert property (
        accept && !sat_mode
        |=> acc_mem[$past(sel)] == $past(cur_acc)
            + {{96{$past(prod[31])}}, $past(prod)})
        else $error("plain accumulate wrong");

    chk_sat_clamp: assert property (
        accept && sat_mode && sum[32] && !sum[31]
        |=> acc_mem[$past(sel)][31:0] == 32'h7FFFFFFF && op_saturated)
        else $error("positive clamp wrong");

    chk_sat_sext: assert property (
        accept && sat_mode
        |=> acc_mem[$past(sel)][127:32]
            == {96{acc_mem[$past(sel)][31]}})
        else $error("saturating result not sign-extended");

    chk_flag_set: assert property (
        accept && sat_mode && acc_ovf
        |=> sat_flags[$past(sel)])
        else $error("overflow flag not set");

    chk_no_exc: assert property (
        accept |=> op_done && !exc_reserved && !exc_ext_disabled)
        else $error("legal op raised exception");

    chk_sat_in_range: assert property (
        accept && sat_mode && sum[32] == sum[31]
        |=> acc_mem[$past(sel)][31:0] == $past(sum[31:0]))
        else $error("in-range saturating sum changed");

    chk_neg_clamp: assert property (
        accept && sat_mode && !sum[32] && sum[31]
        |=> acc_mem[$past(sel)][31:0] == 32'h80000000 && op_saturated)
        else $error("negative-side clamp wrong");

    chk_pair_lane: assert property (
        accept && pair_hit
        |-> lane_a == operand_one_register[15:0]
            && lane_b == operand_two_register[15:0])
        else $error("pair low lane operands wrong");

    chk_pair_halves: assert property (
        accept && pair_hit
        |=> acc_mem[$past(sel)][127:64] == {64{acc_mem[$past(sel)][31]}})
        else $error("pair upper half not sign-extended");

    chk_other_acc: assert property (
        accept && !wr_half
        |=> acc_mem[$past(sel) + 2'h1] == $past(acc_mem[sel + 2'h1]))
        else $error("unselected accumulator changed");

    chk_flag_write: assert property (
        clk_en && wr_ctrl && !(accept && any_sat)
        |=> sat_flags == $past(reg_wdata[qlma_pkg::FLAG_LSB +: 4]))
        else $error("control word write not taken");

    chk_result_forward: assert property (
        accept && !sat_mode ##1 accept && sel == $past(sel)
        |-> cur_acc == $past(sum))
        else $error("back-to-back result not forwarded");

    cov_plain_op: cover property (accept && !sat_mode);
    cov_mul_sat: cover property (accept && mul_sat);
    cov_acc_clamp: cover property (accept && sat_mode && acc_ovf);
    cov_back_to_back: cover property (accept ##1 accept);
    cov_pair_op: cover property (accept && pair_hit);

endmodule

// *** hw/qlma_pkg.sv ***
// Constants and types shared by the Q15 lane multiply-accumulate unit
package qlma_pkg;

    // ------------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------------
    localparam int MAJOR_MSB = 31;
    localparam int MAJOR_LSB = 26;
    localparam int ZERO_MSB  = 15;
    localparam int ZERO_LSB  = 13;
    localparam int SEL_MSB   = 12;
    localparam int SEL_LSB   = 11;
    localparam int SUB_MSB   = 10;
    localparam int SUB_LSB   = 6;
    localparam int FUNC_MSB  = 5;
    localparam int FUNC_LSB  = 0;

    localparam logic [5:0] MAJOR_OP_GROUP3    = 6'h1F;
    localparam logic [5:0] FUNC_QUAD_MAC      = 6'h34;
    localparam logic [5:0] FUNC_PAIR_MAC      = 6'h30;
    localparam logic [2:0] ZERO_FIELD         = 3'h0;
    localparam logic [4:0] SUB_LANE3          = 5'h14;
    localparam logic [4:0] SUB_LANE3_SATACC   = 5'h10;
    localparam logic [4:0] SUB_LANE2          = 5'h15;
    localparam logic [4:0] SUB_LANE2_SATACC   = 5'h11;
    localparam logic [4:0] SUB_LANE1          = 5'h16;
    localparam logic [4:0] SUB_LANE1_SATACC   = 5'h12;
    localparam logic [4:0] SUB_PAIR_LOW_SAT   = 5'h12;

    // ------------------------------------------------------------------
    // Operand lanes and fixed-point constants
    // ------------------------------------------------------------------
    localparam int LANE3_LSB = 48;
    localparam int LANE2_LSB = 32;
    localparam int LANE1_LSB = 16;
    localparam int LANE0_LSB = 0;

    localparam logic [15:0] Q15_NEG_ONE = 16'h8000;
    localparam logic [31:0] Q31_MAX     = 32'h7FFFFFFF;
    localparam logic [31:0] Q31_MIN     = 32'h80000000;

    localparam int ACC_COUNT   = 4;
    localparam int ACC_WIDTH   = 128;
    localparam int HALF_WIDTH  = 64;
    localparam int FLAG_LSB    = 16;

    // ------------------------------------------------------------------
    // Register port map (word indices)
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_ACC_BASE   = 4'h8;
    localparam logic [31:0] CTRL_RESET     = 32'h00000000;
    localparam logic [63:0] HALF_RESET     = 64'h0;

    typedef enum logic [1:0] {
        LANE_LOW,
        LANE_LOWMID,
        LANE_UPMID,
        LANE_TOP
    } qlma_lane_e;

endpackage

// *** dv/qlma_host_model.sv ***
// Issue-stage stand-in for the pipeline feeding the multiply-accumulate unit
`timescale 1ns/100ps
module qlma_host_model (
    input  wire logic        sys_clk,
    input  wire logic        cmd_valid,
    input  wire logic [31:0] cmd_instr,
    input  wire logic [63:0] cmd_a,
    input  wire logic [63:0] cmd_b,
    output logic             issue_valid,
    output logic      [31:0] instr,
    output logic      [63:0] operand_one_register,
    output logic      [63:0] operand_two_register
);
    logic [31:0] last_instr = 32'h0;
    logic [63:0] last_a     = 64'h0;
    logic [63:0] last_b     = 64'h0;

    always @(posedge sys_clk) begin
        if (cmd_valid) begin
            last_instr <= cmd_instr;
            last_a     <= cmd_a;
            last_b     <= cmd_b;
        end
    end

    // Outside an issue slot the buses carry junk, never a stale operand
    assign issue_valid          = cmd_valid;
    assign instr                = cmd_valid ? cmd_instr : ~last_instr;
    assign operand_one_register = cmd_valid ? cmd_a : ~last_a;
    assign operand_two_register = cmd_valid ? cmd_b : ~last_b;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the Q15 lane multiply-accumulate unit
`timescale 1ns/100ps
module testbench;
    localparam logic [5:0]  QUAD = qlma_pkg::FUNC_QUAD_MAC;
    localparam logic [5:0]  PAIR = qlma_pkg::FUNC_PAIR_MAC;
    localparam logic [63:0] OPA  = 64'h4000_2000_E000_1111;
    localparam logic [63:0] OPB  = 64'h3000_C000_5000_7FFF;

    logic         sys_clk    = 1'b0;
    logic         rst        = 1'b1;
    logic         clk_en     = 1'b1;
    logic         ext_enable = 1'b1;
    logic         cmd_valid  = 1'b0;
    logic [31:0]  cmd_instr  = 32'h0;
    logic [63:0]  cmd_a      = 64'h0;
    logic [63:0]  cmd_b      = 64'h0;
    logic [3:0]   reg_addr   = 4'h0;
    logic [63:0]  reg_wdata  = 64'h0;
    logic         reg_wr     = 1'b0;
    logic         reg_rd     = 1'b0;
    logic         issue_valid;
    logic [31:0]  instr;
    logic [63:0]  op_one;
    logic [63:0]  op_two;
    logic [63:0]  reg_rdata;
    logic         op_done;
    logic         op_saturated;
    logic         exc_reserved;
    logic         exc_ext_disabled;
    logic [3:0]   sat_flags;
    logic [127:0] acc_m [4];
    logic [3:0]   flags_m;
    logic [63:0]  rd_hi;
    logic [63:0]  rd_lo;
    logic [5:0]   fn;
    logic [31:0]  i1;
    logic [31:0]  i2;
    logic         s1;
    logic [4:0]   subs [7] = '{qlma_pkg::SUB_LANE3, qlma_pkg::SUB_LANE3_SATACC,
        qlma_pkg::SUB_LANE2, qlma_pkg::SUB_LANE2_SATACC, qlma_pkg::SUB_LANE1,
        qlma_pkg::SUB_LANE1_SATACC, qlma_pkg::SUB_PAIR_LOW_SAT};
    int           num_errors  = 0;
    int           check_count = 0;
    int           cycles      = 0;

    qlma_host_model u_host (
        .sys_clk              (sys_clk),
        .cmd_valid            (cmd_valid),
        .cmd_instr            (cmd_instr),
        .cmd_a                (cmd_a),
        .cmd_b                (cmd_b),
        .issue_valid          (issue_valid),
        .instr                (instr),
        .operand_one_register (op_one),
        .operand_two_register (op_two)
    );

    qlma_mac_unit u_dut (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .clk_en               (clk_en),
        .issue_valid          (issue_valid),
        .instr                (instr),
        .operand_one_register (op_one),
        .operand_two_register (op_two),
        .ext_enable           (ext_enable),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .op_done              (op_done),
        .op_saturated         (op_saturated),
        .exc_reserved         (exc_reserved),
        .exc_ext_disabled     (exc_ext_disabled),
        .sat_flags            (sat_flags)
    );

    always #20 sys_clk = ~sys_clk;

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic results();
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [63:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [63:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic acc_check(input logic [1:0] k);
        reg_read(4'h8 + {1'b0, k, 1'b0}, rd_hi);
        reg_read(4'h9 + {1'b0, k, 1'b0}, rd_lo);
        check({rd_hi, rd_lo}, acc_m[k]);
    endtask

    task automatic acc_load(input logic [1:0] k, input logic [127:0] v);
        reg_write(4'h8 + {1'b0, k, 1'b0}, v[127:64]);
        reg_write(4'h9 + {1'b0, k, 1'b0}, v[63:0]);
        acc_m[k] = v;
    endtask

    function automatic logic [31:0] enc(input logic [1:0] sel,
                                        input logic [4:0] sub,
                                        input logic [5:0] f);
        return {qlma_pkg::MAJOR_OP_GROUP3, 5'h01, 5'h02,
                qlma_pkg::ZERO_FIELD, sel, sub, f};
    endfunction

    // ------------------------------------------------------------------
    // Reference arithmetic and instruction issue
    // ------------------------------------------------------------------
    task automatic expect_op(input logic [31:0] ins, input logic [63:0] a,
                             input logic [63:0] b, output logic sat);
        int                 lsb;
        logic signed [31:0] m;
        logic [31:0]        p;
        logic [127:0]       s;
        logic               ov;
        case (ins[10:6])
            qlma_pkg::SUB_LANE3, qlma_pkg::SUB_LANE3_SATACC: lsb = 48;
            qlma_pkg::SUB_LANE2, qlma_pkg::SUB_LANE2_SATACC: lsb = 32;
            default: lsb = 16;
        endcase
        if (ins[5:0] == PAIR) lsb = 0;
        sat = (a[lsb+:16] == 16'h8000) && (b[lsb+:16] == 16'h8000);
        m = $signed(a[lsb+:16]) * $signed(b[lsb+:16]);
        p = sat ? 32'h7FFFFFFF : {m[30:0], 1'b0};
        s = acc_m[ins[12:11]] + {{96{p[31]}}, p};
        ov = 1'b0;
        // Sub-operation bit two clear marks the saturating forms
        if (!ins[8]) begin
            ov = s[32] != s[31];
            if (ov) s[31:0] = s[32] ? 32'h7FFFFFFF : 32'h80000000;
            s = {{96{s[31]}}, s[31:0]};
        end
        acc_m[ins[12:11]] = s;
        sat = sat | ov;
        if (sat) flags_m[ins[12:11]] = 1'b1;
    endtask

    task automatic issue_raw(input logic [31:0] ins, input logic [63:0] a,
                             input logic [63:0] b, input logic en);
        @(posedge sys_clk);
        cmd_valid  <= 1'b1;
        cmd_instr  <= ins;
        cmd_a      <= a;
        cmd_b      <= b;
        ext_enable <= en;
        @(posedge sys_clk);
        cmd_valid  <= 1'b0;
        ext_enable <= 1'b1;
        #1;
    endtask

    task automatic mac(input logic [31:0] ins, input logic [63:0] a,
                       input logic [63:0] b);
        logic sat;
        expect_op(ins, a, b, sat);
        issue_raw(ins, a, b, 1'b1);
        check(128'(op_done), 128'h1);
        check(128'(op_saturated), 128'(sat));
        check(128'(sat_flags), 128'(flags_m));
        acc_check(ins[12:11]);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        flags_m = 4'h0;
        foreach (acc_m[k]) acc_m[k] = 128'h0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        reg_read(qlma_pkg::REG_CTRL, rd_lo);
        check(128'(rd_lo), 128'(qlma_pkg::CTRL_RESET));
        acc_check(2'h0);
        for (int i = 0; i < 7; i++) begin
            fn = (i == 6) ? PAIR : QUAD;
            mac(enc(2'(i), subs[i], fn), OPA, OPB);
        end
        mac(enc(2'h1, subs[0], QUAD), {16'h8000, 48'h0}, {16'h8000, 48'h0});
        acc_load(2'h2, 128'h7FFF_FFF0);
        mac(enc(2'h2, subs[3], QUAD), OPA, {16'h0, 16'h4000, 32'h0});
        acc_load(2'h3, {96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF, 32'h8000_0010});
        mac(enc(2'h3, subs[5], QUAD), OPA, {32'h0, 16'h4000, 16'h0});
        acc_load(2'h0, 128'hFFFF_FFFF_FFFF_FFFF);
        mac(enc(2'h0, subs[0], QUAD), OPA, {16'h4000, 48'h0});
        // Back-to-back issue into one accumulator
        i1 = enc(2'h1, subs[2], QUAD);
        i2 = enc(2'h1, subs[3], QUAD);
        expect_op(i1, OPA, OPB, s1);
        expect_op(i2, OPA, OPB, s1);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_instr <= i1;
        cmd_a     <= OPA;
        cmd_b     <= OPB;
        @(posedge sys_clk);
        cmd_instr <= i2;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
        check(128'(op_done), 128'h1);
        acc_check(2'h1);
        issue_raw(enc(2'h3, subs[0], QUAD) | 32'h0000_2000, OPA, OPB, 1'b1);
        check(128'(exc_reserved), 128'h1);
        check(128'(op_done), 128'h0);
        issue_raw(enc(2'h3, subs[0], QUAD), OPA, OPB, 1'b0);
        check(128'(exc_ext_disabled), 128'h1);
        acc_check(2'h3);
        // Frozen clock enable: the issue is lost and nothing moves
        @(posedge sys_clk);
        clk_en <= 1'b0;
        issue_raw(enc(2'h3, subs[0], QUAD), OPA, OPB, 1'b1);
        check(128'(op_done), 128'h0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        acc_check(2'h3);
        reg_write(qlma_pkg::REG_CTRL, 64'h0);
        reg_read(qlma_pkg::REG_CTRL, rd_lo);
        check(128'(rd_lo), 128'h0);
        reg_read(4'h3, rd_lo);
        check(128'(rd_lo), 128'h0);
        results();
    end
endmodule
